/* File: card_mech_model.sv */
// Purpose: Behavioural card mechanism at the far side of the controller.
// Assumes: A feed brings a card in 21 cycles, then 81 column times.
// Notes: Column data is inverted between strobes so stale data is not kept.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Mechanism
// ****************************************
module card_mech_model
(
   input wire logic clk,
   input wire logic rst,
   input wire logic feed_cmd,
   input wire logic stall,
   input wire logic punch_valid,
   input wire logic [11:0] punch_column,
   output logic col_strobe,
   output logic card_at_station,
   output logic [11:0] read_column,
   output logic punch_ready,
   output logic [11:0] last_punch,
   output logic mech_run
);
   logic [5:0] ph_q;
   logic [6:0] col_q;
   logic [4:0] wait_q;
   assign punch_ready = !stall;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         col_strobe <= 1'b0;
         card_at_station <= 1'b1;
         read_column <= 12'h000;
         mech_run <= 1'b0;
         ph_q <= 6'h00;
         col_q <= 7'h00;
         wait_q <= 5'h00;
      end
      else if (feed_cmd)
      begin
         card_at_station <= 1'b0;
         mech_run <= 1'b1;
         wait_q <= 5'h00;
         ph_q <= 6'h00;
         col_q <= 7'h00;
      end
      else if (mech_run && !card_at_station)
      begin
         wait_q <= wait_q + 5'h01;
         card_at_station <= wait_q == 5'h14;
      end
      else if (mech_run)
      begin
         ph_q <= ph_q == 6'h27 ? 6'h00 : ph_q + 6'h01;
         if (ph_q == 6'h00)
         begin
            col_strobe <= 1'b1;
            col_q <= col_q + 7'h01;
            read_column <= 12'hA00 | {5'h00, col_q + 7'h01};
         end
         if (ph_q == 6'h04)
            col_strobe <= 1'b0;
         if (ph_q == 6'h08)
            read_column <= ~read_column;
         if (ph_q == 6'h0A && col_q == 7'h51)
            mech_run <= 1'b0;
      end
   end
   always_ff @(posedge clk)
   begin
      if (rst)
         last_punch <= 12'h000;
      else if (punch_valid && punch_ready)
         last_punch <= punch_column;
   end
endmodule
`default_nettype wire

/* File: card_reader_punch_channel_control.sv */
// What this block does
// (RL1) Punch busy sets at first punch data Reply; clears on feed or column 81.
// (RL2) Read operation starts at reader feed; ends at column 81 or lost data.
// (RL3) Reader and punch operations never overlap.
// (RL4) Punch operation starts at first punch word; ends at column 81.
// (RL5) Feed ending an operation early gives no end-of-operation status.
// (RL6) Not-ready alarm follows chip box, hopper, stacker, transport, lid causes.
// (RL7) Ready alarm on lost data or check error, held until clear.
// (RL8) Not ready when any of seven ready conditions is missing.
// (RL9) Pre-read error when amplifiers fail the light or dark check.
// (RL10) Punch error when the echo check finds a faulty signal.
// (RL11) Transport fault on feed failure or jam in any area.
// (RL12) Respond only when the converter field is zero.
// (RL13) Respond only when the unit field matches the equipment switches.
// (RL14) Bit 5 alone selects reader, bit 6 alone selects punch.
// (RL15) Station bits both set or both clear: no Reply, no Reject.
// (RL16) Bit 0 picks data or director; with Read, bit 1 picks status level.
// (RL17) Reject reader data when not ready, too fast, past column 80, or feeding.
// (RL18) Reject punch data when not ready, too fast, or past column 80; the code rejects only at column count 80.
// (RL19) All director bits in one word are carried out together.
// (RL20) Clear-all clears clearable state; request, feed, offset bits win.
// (RL21) Clear-all works while not ready if only clear-interrupts accompanies it.
// (RL22) Clear-interrupts clears requests and responses; request bits win.
// (RL23) Data word holds one column in low 12 bits, bit 0 is row 9.
// (RL24) Reader busy sets at feed start; clears at column 81 or lost data.
// (RL25) After lost data no more columns move and end-of-operation rises.
// (RL26) Exactly one Reply or Reject answers each accepted request; the code gives neither to a punch data read or a reader data write.
// (RL27) Master clear returns all operation, busy, alarm, error state to idle.
// Purpose: Channel-side control for a column card reader/punch mechanism.
// Assumes: Mechanism signals are asynchronous; all but punch_ready pass two flip-flops.
// Notes: The host holds address and data until Reply or Reject.
`timescale 1ns/1ps
`default_nettype none
module card_reader_punch_channel_control
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] chan_addr,
   input wire logic [15:0] chan_wdata,
   input wire logic chan_read,
   input wire logic chan_write,
   output logic [15:0] chan_rdata,
   output logic chan_reply,
   output logic chan_reject,
   output logic chan_irq,
   input wire logic [3:0] equip_switch,
   input wire logic power_ok,
   input wire logic hopper_empty,
   input wire logic stacker_full,
   input wire logic chip_box_bad,
   input wire logic lid_open,
   input wire logic fail_to_feed,
   input wire logic jam,
   input wire logic light_fail,
   input wire logic dark_fail,
   input wire logic echo_fault,
   input wire logic col_strobe,
   input wire logic card_at_station,
   input wire logic [11:0] read_column,
   output logic feed_cmd,
   output logic offset_cmd,
   output logic punch_valid,
   input wire logic punch_ready,
   output logic [11:0] punch_column
);
   // ******************************************************
   // Input synchronisers
   // ******************************************************
   localparam int NS = 12;
   logic [NS-1:0] raw_in;
   logic [NS-1:0] s1_q;
   logic [NS-1:0] s2_q;
   logic [11:0] col1_q;
   logic [11:0] col2_q;
   logic strobe_d_q;
   assign raw_in = {power_ok, hopper_empty, stacker_full, chip_box_bad,
                    lid_open, fail_to_feed, jam, light_fail, dark_fail,
                    echo_fault, col_strobe, card_at_station};

   always_ff @(posedge clk)
   begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      col1_q <= read_column;
      col2_q <= col1_q;
      strobe_d_q <= s2_q[1];
   end

   logic pwr;
   logic hop_e;
   logic stk_f;
   logic chip_b;
   logic lid_o;
   logic ftf;
   logic jam_s;
   logic lfail;
   logic dfail;
   logic efault;
   logic col_pulse;
   logic at_station;
   assign {pwr, hop_e, stk_f, chip_b, lid_o, ftf, jam_s, lfail, dfail,
           efault} = s2_q[NS-1:2];
   assign col_pulse = s2_q[1] && !strobe_d_q;
   assign at_station = s2_q[0];

   // ******************************************************
   // Address decode
   // ******************************************************
   logic sel;
   logic rdr_sel;
   logic pch_sel;
   logic req;
   logic director;
   logic do_rdata;
   logic do_wdata;
   logic do_func;
   logic do_stat;
   logic transport_fault;
   logic ready;
   logic alarm_nr;
   logic [15:0] fn;
   assign sel = (chan_addr[crp_pkg::ADDR_CONV_HI:crp_pkg::ADDR_CONV_LO]
                 == crp_pkg::CONV_ZERO) // [RL12]
                && (chan_addr[crp_pkg::ADDR_EQ_HI:crp_pkg::ADDR_EQ_LO]
                 == equip_switch); // [RL13]
   assign rdr_sel = chan_addr[crp_pkg::ADDR_RDR_BIT]
                    && !chan_addr[crp_pkg::ADDR_PCH_BIT]; // [RL14]
   assign pch_sel = !chan_addr[crp_pkg::ADDR_RDR_BIT]
                    && chan_addr[crp_pkg::ADDR_PCH_BIT]; // [RL14]
   logic busy_ans_q;
   assign req = sel && (rdr_sel || pch_sel) && !busy_ans_q // [RL15]
                && (chan_read ^ chan_write);
   assign director = chan_addr[crp_pkg::ADDR_DIR_BIT];
   assign do_rdata = req && !director && chan_read && rdr_sel; // [RL16]
   assign do_wdata = req && !director && chan_write && pch_sel;
   assign do_func = req && director && chan_write;
   assign do_stat = req && director && chan_read;
   assign fn = chan_wdata;

   // ******************************************************
   // Condition and alarm logic
   // ******************************************************
   assign transport_fault = ftf || jam_s; // [RL11]
   assign alarm_nr = chip_b || hop_e || stk_f || transport_fault
                     || lid_o; // [RL6]
   assign ready = pwr && !hop_e && !stk_f && !jam_s && !ftf && !chip_b
                  && !lid_o; // [RL8]

   // ******************************************************
   // Operation state
   // ******************************************************
   logic rd_busy_q;
   logic pch_busy_q;
   logic lost_q;
   logic preread_err_q;
   logic punch_err_q;
   logic eop_rd_q;
   logic eop_pch_q;
   logic rd_avail_q;
   logic feeding_q;
   logic [6:0] col_q;
   logic [11:0] rd_col_q;
   logic irq_data_q;
   logic irq_eop_q;
   logic irq_alarm_q;
   logic clr_all;
   logic clr_int;
   logic feed_ok;
   logic col_end;
   logic fifo_in_ready;
   logic rdr_reject;
   logic pch_reject;
   logic fn_reply;
   logic answer;
   assign clr_all = do_func && fn[crp_pkg::FN_CLEAR_ALL];
   assign clr_int = do_func && (fn[crp_pkg::FN_CLEAR_INT] || clr_all);
   assign feed_ok = do_func && ready && fn[crp_pkg::FN_FEED];
   assign col_end = col_pulse && (col_q == crp_pkg::LAST_COL);
   assign rdr_reject = !ready || !rd_avail_q || lost_q || feeding_q
                       || !rd_busy_q; // [RL17]
   assign pch_reject = !ready || !fifo_in_ready || rd_busy_q
                       || (col_q == crp_pkg::LAST_COL) || feeding_q; // [RL18]
   // Non-clear functions need ready; a bare clear is accepted anyway.
   assign fn_reply = ready || ((fn & crp_pkg::FN_OTHER_MASK) == '0); // [RL21]

   always_ff @(posedge clk)
   begin
      if (rst || (clr_all && fn_reply && !feed_ok)) // [RL27] [RL20]
      begin
         rd_busy_q <= 1'b0;
         pch_busy_q <= 1'b0;
         feeding_q <= 1'b0;
         col_q <= '0;
         rd_avail_q <= 1'b0;
         eop_rd_q <= 1'b0;
         eop_pch_q <= 1'b0;
      end
      else
      begin
         if (feed_ok) // [RL19]
         begin
            feeding_q <= 1'b1;
            col_q <= '0;
            rd_avail_q <= 1'b0;
            pch_busy_q <= 1'b0; // [RL1]
            // Early termination by feed reports no end of operation.
            eop_rd_q <= 1'b0; // [RL5]
            eop_pch_q <= 1'b0;
            rd_busy_q <= rdr_sel && !pch_busy_q; // [RL2] [RL24] [RL3]
         end
         else
         begin
            if (feeding_q && at_station)
            begin
               feeding_q <= 1'b0;
            end
            if (do_wdata && !pch_reject && !pch_busy_q)
            begin
               pch_busy_q <= 1'b1; // [RL1] [RL4]
            end
            if (do_rdata && !rdr_reject)
            begin
               rd_avail_q <= 1'b0;
            end
            if (col_pulse && !feeding_q)
            begin
               col_q <= col_q + 7'h01;
               rd_avail_q <= rd_busy_q && !lost_q;
            end
            if (col_end || (rd_busy_q && lost_q)) // [RL25]
            begin
               rd_busy_q <= 1'b0; // [RL24] [RL2]
               eop_rd_q <= rd_busy_q || eop_rd_q;
            end
            if (col_end && pch_busy_q)
            begin
               pch_busy_q <= 1'b0; // [RL4]
               eop_pch_q <= 1'b1;
            end
         end
      end
   end

   // ******************************************************
   // Errors: sticky until master clear or clear-all
   // ******************************************************
   always_ff @(posedge clk)
   begin
      if (rst || (clr_all && fn_reply)) // [RL7] [RL27]
      begin
         lost_q <= 1'b0;
         preread_err_q <= 1'b0;
         punch_err_q <= 1'b0;
      end
      if (!rst && col_pulse && rd_avail_q && rd_busy_q && !do_rdata)
      begin
         lost_q <= 1'b1; // [RL7]
      end
      if (!rst && feed_ok && rdr_sel && (lfail || dfail))
      begin
         preread_err_q <= 1'b1; // [RL9] [RL20]
      end
      if (!rst && efault)
      begin
         punch_err_q <= 1'b1; // [RL10]
      end
   end

   always_ff @(posedge clk)
   begin
      if (col_pulse && rd_busy_q)
      begin
         rd_col_q <= col2_q; // [RL23]
      end
   end

   // ******************************************************
   // Interrupt requests: request bits win over clears
   // ******************************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         irq_data_q <= 1'b0;
         irq_eop_q <= 1'b0;
         irq_alarm_q <= 1'b0;
      end
      else if (do_func && fn_reply)
      begin
         irq_data_q <= fn[crp_pkg::FN_DATA_IRQ] || (irq_data_q && !clr_int);
         irq_eop_q <= fn[crp_pkg::FN_EOP_IRQ] || (irq_eop_q && !clr_int);
         irq_alarm_q <= fn[crp_pkg::FN_ALARM_IRQ]
                        || (irq_alarm_q && !clr_int); // [RL22] [RL20]
      end
   end

   logic alarm_any;
   assign alarm_any = alarm_nr || lost_q || preread_err_q || punch_err_q;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         chan_irq <= 1'b0;
      end
      else
      begin
         chan_irq <= (irq_data_q && (rd_avail_q || (pch_busy_q
                      && fifo_in_ready))) || (irq_eop_q && (eop_rd_q
                      || eop_pch_q)) || (irq_alarm_q && alarm_any);
      end
   end

   // ******************************************************
   // Punch column FIFO
   // ******************************************************
   logic fifo_push;
   assign fifo_push = do_wdata && !pch_reject;
   crp_fifo #(.WIDTH(crp_pkg::COL_W), .DEPTH(crp_pkg::FIFO_DEPTH)) u_fifo
   (
      .clk(clk),
      .rst(rst),
      .flush(feed_ok || (clr_all && fn_reply)),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(chan_wdata[crp_pkg::COL_W-1:0]), // [RL23]
      .out_valid(punch_valid),
      .out_ready(punch_ready),
      .out_data(punch_column)
   );

   // ******************************************************
   // Channel answer
   // ******************************************************
   // At most one answer per request; the answer latch blocks repeats while held.
   assign answer = do_rdata || do_wdata || do_func || do_stat; // [RL26]
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         busy_ans_q <= 1'b0;
         chan_reply <= 1'b0;
         chan_reject <= 1'b0;
         chan_rdata <= '0;
         feed_cmd <= 1'b0;
         offset_cmd <= 1'b0;
      end
      else
      begin
         busy_ans_q <= answer || (busy_ans_q && (chan_read || chan_write));
         chan_reply <= (do_rdata && !rdr_reject) || (do_wdata && !pch_reject)
                       || (do_func && fn_reply) || do_stat; // [RL26]
         chan_reject <= (do_rdata && rdr_reject) || (do_wdata && pch_reject)
                        || (do_func && !fn_reply);
         feed_cmd <= feed_ok;
         offset_cmd <= do_func && ready && fn[crp_pkg::FN_OFFSET];
         if (do_rdata && !rdr_reject)
         begin
            chan_rdata <= {4'h0, rd_col_q};
         end
         else if (do_stat && !chan_addr[crp_pkg::ADDR_LVL_BIT])
         begin
            chan_rdata <= {7'h00, preread_err_q || punch_err_q, 1'b0, lost_q,
                           1'b0, eop_rd_q || eop_pch_q, rd_avail_q, chan_irq,
                           rd_busy_q || pch_busy_q, ready};
         end
         else if (do_stat)
         begin
            chan_rdata <= {8'h00, punch_err_q, preread_err_q, 1'b0, jam_s,
                           1'b0, ftf, stk_f, hop_e};
         end
      end
   end
endmodule
`default_nettype wire

/* File: card_reader_punch_channel_control_chk.sv */
// Purpose: Concurrent checks on the channel side of the card controller.
// Assumes: One clock; rst is a synchronous active-high master clear.
// Notes: Only top-level ports are watched.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Checker
// ****************************************
module crp_chk
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] chan_addr,
   input wire logic [15:0] chan_wdata,
   input wire logic chan_read,
   input wire logic chan_write,
   input wire logic chan_reply,
   input wire logic chan_reject,
   input wire logic chan_irq,
   input wire logic [3:0] equip_switch,
   input wire logic hopper_empty,
   input wire logic feed_cmd,
   input wire logic offset_cmd,
   input wire logic punch_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic req;
   logic sel_ok;
   assign req = chan_read | chan_write;
   assign sel_ok = chan_addr[15:11] == 5'h00 && chan_addr[10:7] == equip_switch
      && chan_addr[5] != chan_addr[6];
   ans_excl_a: assert property (!(chan_reply && chan_reject))
      else $error("reply and reject together");
   ans_once_a: assert property (req && !$past(req) && sel_ok |=>
      chan_reply ^ chan_reject) else $error("request not answered");
   ans_short_a: assert property (chan_reply |=> !chan_reply)
      else $error("reply longer than one cycle");
   bad_station_a: assert property (req && !$past(req) &&
      chan_addr[5] == chan_addr[6] |=> !chan_reply && !chan_reject)
      else $error("answer to invalid station");
   wrong_unit_a: assert property (req && !$past(req) &&
      chan_addr[10:7] != equip_switch |=> !chan_reply && !chan_reject)
      else $error("answer to other unit");
   conv_field_a: assert property (req && !$past(req) &&
      chan_addr[15:11] != 5'h00 |=> !chan_reply && !chan_reject)
      else $error("answer with converter field set");
   feed_pulse_a: assert property (chan_reply && $past(chan_write &&
      chan_addr[0] && chan_wdata[7]) |-> feed_cmd)
      else $error("feed bit without feed pulse");
   offset_pulse_a: assert property (chan_reply && $past(chan_write &&
      chan_addr[0] && chan_wdata[8]) |-> offset_cmd)
      else $error("offset bit without offset pulse");
   notready_rej_a: assert property (req && !$past(req) && sel_ok &&
      chan_read && !chan_addr[0] && hopper_empty && $past(hopper_empty, 4)
      |=> chan_reject) else $error("read data taken while not ready");
   reset_idle_a: assert property ($past(rst) |-> !chan_reply &&
      !chan_reject && !feed_cmd && !offset_cmd && !chan_irq && !punch_valid)
      else $error("outputs active after master clear");
endmodule
bind card_reader_punch_channel_control crp_chk crp_chk_inst (.clk(clk),
   .rst(rst), .chan_addr(chan_addr), .chan_wdata(chan_wdata),
   .chan_read(chan_read), .chan_write(chan_write), .chan_reply(chan_reply),
   .chan_reject(chan_reject), .chan_irq(chan_irq),
   .equip_switch(equip_switch), .hopper_empty(hopper_empty),
   .feed_cmd(feed_cmd), .offset_cmd(offset_cmd), .punch_valid(punch_valid));
`default_nettype wire

/* File: card_reader_punch_channel_control_test.sv */
// Purpose: Directed test of the card reader/punch channel control.
// Assumes: Mechanism model on the far side; one request at a time.
// Notes: Answers are sampled at the edge where they stand.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Testbench
// ****************************************
module card_reader_punch_channel_control_test;
   localparam logic [3:0] EQ = 4'h9;
   localparam logic [1:0] RDR = 2'h1, PCH = 2'h2, RPL = 2'h1, RJT = 2'h2;
   logic clk = 1'b0, rst = 1'b1, chan_read = 1'b0, chan_write = 1'b0;
   logic power_ok = 1'b1, hopper_empty = 1'b0, stacker_full = 1'b0;
   logic chip_box_bad = 1'b0, lid_open = 1'b0, jam = 1'b0;
   logic light_fail = 1'b0, stall = 1'b0;
   logic [15:0] chan_addr = 16'h0000, chan_wdata = 16'h0000, chan_rdata, rd;
   logic chan_reply, chan_reject, chan_irq, feed_cmd, offset_cmd, punch_valid;
   logic punch_ready, col_strobe, card_at_station, mech_run;
   logic [11:0] read_column, punch_column, last_punch;
   logic [1:0] res;
   int error_cnt = 0, tests_run = 0;
   card_reader_punch_channel_control card_reader_punch_channel_control_inst (
      .clk(clk), .rst(rst), .chan_addr(chan_addr), .chan_wdata(chan_wdata),
      .chan_read(chan_read), .chan_write(chan_write), .chan_rdata(chan_rdata),
      .chan_reply(chan_reply), .chan_reject(chan_reject), .chan_irq(chan_irq),
      .equip_switch(EQ), .power_ok(power_ok), .hopper_empty(hopper_empty),
      .stacker_full(stacker_full), .chip_box_bad(chip_box_bad),
      .lid_open(lid_open), .fail_to_feed(1'b0), .jam(jam),
      .light_fail(light_fail), .dark_fail(1'b0), .echo_fault(1'b0),
      .col_strobe(col_strobe), .card_at_station(card_at_station),
      .read_column(read_column), .feed_cmd(feed_cmd), .offset_cmd(offset_cmd),
      .punch_valid(punch_valid), .punch_ready(punch_ready),
      .punch_column(punch_column));
   card_mech_model card_mech_model_inst (.clk(clk), .rst(rst),
      .feed_cmd(feed_cmd), .stall(stall), .punch_valid(punch_valid),
      .punch_column(punch_column), .col_strobe(col_strobe),
      .card_at_station(card_at_station), .read_column(read_column),
      .punch_ready(punch_ready), .last_punch(last_punch), .mech_run(mech_run));
   initial forever #4 clk = ~clk;
   function automatic logic [15:0] mk(input logic [1:0] st, input logic lvl,
      input logic dir);
      return {5'h00, EQ, st, 3'h0, lvl, dir};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
      input string msg);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   // Holds the request until an answer is sampled, or six edges pass.
   task automatic xfer(input logic wr, input logic [15:0] a,
      input logic [15:0] d);
      @(posedge clk);
      chan_addr <= a;
      chan_wdata <= d;
      chan_read <= !wr;
      chan_write <= wr;
      res = 2'h0;
      for (int i = 0; i < 6 && res == 2'h0; i++)
      begin
         @(posedge clk);
         res = {chan_reject === 1'b1, chan_reply === 1'b1};
      end
      rd = chan_rdata;
      chan_read <= 1'b0;
      chan_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic stat(input logic lvl);
      xfer(1'b0, mk(RDR, lvl, 1'b1), 16'h0000);
   endtask
   task automatic func(input logic [1:0] st, input logic [15:0] f);
      xfer(1'b1, mk(st, 1'b0, 1'b1), f);
   endtask
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         xfer(1'b0, i == 0 ? mk(RDR, 0, 1) | 16'h0800 : i == 1 ?
            mk(RDR, 0, 1) ^ 16'h0080 : mk(i == 2 ? 2'h0 : 2'h3, 0, 1), 16'h0);
         check({14'h0, res}, 16'h0, "foreign");
      end
      stat(1'b0);
      check(rd & 16'h0113, 16'h0001, "idle status");
      for (int i = 0; i < 6; i++)
      begin
         {jam, lid_open, chip_box_bad, stacker_full, hopper_empty, power_ok}
            <= 6'h01 ^ (6'h01 << i);
         repeat (4) @(posedge clk);
         stat(1'b0);
         check(rd & 16'h0001, 16'h0000, "ready with cause");
         stat(1'b1);
         check(rd & 16'h0001, {15'h0, i == 1}, "hopper status");
         xfer(1'b0, mk(RDR, 0, 0), 16'h0);
         check({14'h0, res}, {14'h0, RJT}, "read not ready");
         func(RDR, 16'h0080);
         check({14'h0, res}, {14'h0, RJT}, "feed not ready");
         func(RDR, 16'h0003);
         check({14'h0, res}, {14'h0, RPL}, "clear not ready");
         {jam, lid_open, chip_box_bad, stacker_full, hopper_empty, power_ok}
            <= 6'h01;
         repeat (4) @(posedge clk);
         func(RDR, 16'h0001);
         stat(1'b0);
         check(rd & 16'h0001, 16'h0001, "repaired");
      end
      func(RDR, 16'h0080);
      check({14'h0, res}, {14'h0, RPL}, "reader feed");
      stat(1'b0);
      check(rd & 16'h0002, 16'h0002, "reader busy");
      xfer(1'b1, mk(PCH, 0, 0), 16'h0123);
      check({14'h0, res}, {14'h0, RJT}, "punch in read");
      for (int k = 1; k <= 80; k++)
      begin
         for (int n = 0; n < 60 && !(n > 0 && res == RPL); n++)
            xfer(1'b0, mk(RDR, 0, 0), 16'h0);
         check(rd & 16'h0FFF, {4'h0, 4'hA, 8'(k)}, "column data");
      end
      xfer(1'b0, mk(RDR, 0, 0), 16'h0);
      check({14'h0, res}, {14'h0, RJT}, "read past column 80");
      for (int n = 0; n < 100 && (n == 0 || rd[1] !== 1'b0); n++)
         stat(1'b0);
      check(rd & 16'h0052, 16'h0010, "card complete");
      light_fail <= 1'b1;
      repeat (4) @(posedge clk);
      func(RDR, 16'h0181);
      check({14'h0, res}, {14'h0, RPL}, "stacked functions");
      light_fail <= 1'b0;
      for (int n = 0; n < 100 && (n == 0 || rd[6] !== 1'b1); n++)
         stat(1'b0);
      check(rd & 16'h0153, 16'h0151, "lost data");
      stat(1'b1);
      check(rd & 16'h0040, 16'h0040, "pre-read error");
      func(RDR, 16'h0001);
      stat(1'b0);
      check(rd & 16'h0140, 16'h0000, "clear all");
      for (int n = 0; n < 5000 && mech_run !== 1'b0; n++)
         @(posedge clk);
      check({15'h0, mech_run}, 16'h0, "mech");
      stall <= 1'b1;
      for (int k = 0; k < 9; k++)
      begin
         xfer(1'b1, mk(PCH, 0, 0), 16'hAF00 | 16'(k));
         check({14'h0, res}, {14'h0, k < 8 ? RPL : RJT}, "fill");
      end
      stat(1'b0);
      check(rd & 16'h0002, 16'h0002, "punch busy");
      stall <= 1'b0;
      repeat (40) @(posedge clk);
      check({4'h0, last_punch}, 16'h0F07, "last punched column");
      func(PCH, 16'h0080);
      stat(1'b0);
      check(rd & 16'h0012, 16'h0000, "feed ends punch");
      func(PCH, 16'h0010);
      lid_open <= 1'b1;
      repeat (4) @(posedge clk);
      check({15'h0, chan_irq}, 16'h0001, "alarm irq");
      func(PCH, 16'h0002);
      check({15'h0, chan_irq}, 16'h0000, "irq clear");
      lid_open <= 1'b0;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      stat(1'b0);
      check(rd & 16'h0152, 16'h0000, "state after clear");
      end_of_test();
   end
endmodule
`default_nettype wire

/* File: crp_fifo.sv */
// Purpose: Small flip-flop FIFO for card column words.
// Assumes: One clock, synchronous active-high reset.
// Notes: Full and empty are exact; no write when full, no read when empty.
`timescale 1ns/1ps
`default_nettype none
module crp_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst || flush)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
         end
         if (pop)
         begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

/* File: crp_pkg.sv */
// Purpose: Shared constants for the card reader/punch channel control.
// Assumes: 16-bit channel words, one 125 MHz clock.
// Notes: Address and function bit positions are named here.
package crp_pkg;
   localparam int WORD_W = 16;
   localparam int COL_W = 12;
   localparam int FIFO_DEPTH = 8;
   localparam int ADDR_DIR_BIT = 0;
   localparam int ADDR_LVL_BIT = 1;
   localparam int ADDR_RDR_BIT = 5;
   localparam int ADDR_PCH_BIT = 6;
   localparam int ADDR_EQ_LO = 7;
   localparam int ADDR_EQ_HI = 10;
   localparam int ADDR_CONV_LO = 11;
   localparam int ADDR_CONV_HI = 15;
   localparam int FN_CLEAR_ALL = 0;
   localparam int FN_CLEAR_INT = 1;
   localparam int FN_DATA_IRQ = 2;
   localparam int FN_EOP_IRQ = 3;
   localparam int FN_ALARM_IRQ = 4;
   localparam int FN_FEED = 7;
   localparam int FN_OFFSET = 8;
   localparam logic [15:0] FN_OTHER_MASK = 16'h01FC;
   localparam logic [4:0] CONV_ZERO = 5'h00;
   localparam logic [6:0] LAST_COL = 7'h50;
endpackage
